// >>> design/abp_arbiter.sv
// backplane bus master, dma arbiter and processor trap front end
// What this block does
// - grant only when idle, sync not driven
// - halt held 25 us enters console mode
// - refresh line marks refresh on refresh_seen
// - power-ok loss outside console mode starts powerfail trap
// - external event vectors through address 100
// - data-out only after data deskewed, reply ends
// - data-in with sync; sample after reply deskew
// - data-in without sync is interrupt acknowledge
// - sync after address; negation ends transfer
// - write/byte at sync edge, again for byte
// - level four acknowledged when mask bit clear
// - io page select; slaves decode low 13 bits
// - sixteen lines carry address then data
// - extended address lines unused during data
// - bus signals active low except power-ok and address/data lines
`timescale 1ns/10ps
module abp_arbiter
  import abp_pkg::*;
#(
  parameter int HALT_CYC = ABP_HALT_CYC,
  parameter int DESKEW_CYC = ABP_DESKEW_CYC
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cpu_req,
  input wire logic cpu_write,
  input wire logic cpu_byte,
  input wire logic [ABP_AW-1:0] cpu_addr,
  input wire logic [ABP_DW-1:0] cpu_wdata,
  output logic cpu_ready,
  output logic [ABP_DW-1:0] cpu_rdata,
  input wire logic priority_mask_bit,
  output logic [2:0] trap_cause,
  output logic [ABP_DW-1:0] trap_vector,
  output logic trap_valid,
  input wire logic trap_taken,
  output logic console_mode,
  input wire logic [ABP_AW-1:0] addr_data_lines_in,
  output logic [ABP_AW-1:0] addr_data_lines_out,
  output logic addr_data_lines_oe_n,
  output logic sync_strobe_n,
  output logic data_in_strobe_n,
  output logic data_out_strobe_n,
  output logic write_byte_select_n,
  output logic io_page_select_n,
  output logic irq_ack_chain_out_n,
  output logic dma_grant_out_n,
  output logic bus_initialise_n,
  input wire logic slave_reply_n,
  input wire logic dma_request_n,
  input wire logic grant_acknowledge_n,
  input wire logic processor_halt_n,
  input wire logic memory_refresh_n,
  input wire logic external_event_irq_n,
  input wire logic irq_level_four_n,
  input wire logic power_ok,
  input wire logic dc_power_ok,
  output logic refresh_seen
);
  localparam int NS = 9;
  localparam int DCW = $clog2(DESKEW_CYC + 1);
  localparam logic [DCW-1:0] DSK = DCW'(DESKEW_CYC);

  typedef struct packed {
    abp_state_t st;
    logic [DCW-1:0] dly;
    logic [ABP_AW-1:0] dal;
    logic dal_drv;
    logic sync;
    logic din;
    logic dout;
    logic wtbt;
    logic bs7;
    logic ack_out;
    logic grant;
    logic [ABP_DW-1:0] rdata;
    logic ready;
    logic [2:0] cause;
    logic tvalid;
    logic console;
    logic pok_prev;
    logic halt_done;
    logic event_prev;
    logic pfail_pend;
    logic event_pend;
    logic refr;
  } abp_regs_t;

  abp_regs_t cur_ff;
  abp_regs_t nxt_cur;

  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn_in;
  logic reply;
  logic dmr;
  logic sack;
  logic halt;
  logic memory_refresh;
  logic evnt;
  logic irq4;
  logic pok;
  logic dcok;
  logic halt_long;

  // bus strobes arrive active low; power-ok lines are active high
  assign raw_in = {!slave_reply_n, !dma_request_n, !grant_acknowledge_n,
                   !processor_halt_n, !memory_refresh_n,
                   !external_event_irq_n, !irq_level_four_n,
                   power_ok, dc_power_ok};

  abp_sync #(.WIDTH(NS)) abp_sync_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(raw_in),
    .sync_out(syn_in)
  );

  assign {reply, dmr, sack, halt, memory_refresh, evnt, irq4, pok, dcok} = syn_in;

  abp_halt_timer #(.HALT_CYC(HALT_CYC)) abp_halt_timer_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .halt_level(halt),
    .halt_long(halt_long)
  );

  function automatic logic is_io_page(input logic [ABP_AW-1:0] a);
    return &a[ABP_AW-1:ABP_IOPAGE_AW];
  endfunction

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.ready = 1'b0;
    nxt_cur.pok_prev = pok;
    nxt_cur.event_prev = evnt;
    nxt_cur.halt_done = halt_long;
    nxt_cur.refr = memory_refresh;
    if (cur_ff.pok_prev && !pok && !cur_ff.console)
      nxt_cur.pfail_pend = 1'b1;
    if (evnt && !cur_ff.event_prev)
      nxt_cur.event_pend = 1'b1;
    if (trap_taken && cur_ff.tvalid)
    begin
      nxt_cur.tvalid = 1'b0;
      nxt_cur.cause = ABP_CAUSE_NONE;
    end
    if (!cur_ff.tvalid || trap_taken)
    begin
      if (halt_long && !cur_ff.halt_done)
      begin
        nxt_cur.console = 1'b1;
        nxt_cur.tvalid = 1'b1;
        nxt_cur.cause = ABP_CAUSE_HALT;
      end
      else if (nxt_cur.pfail_pend)
      begin
        nxt_cur.pfail_pend = 1'b0;
        nxt_cur.tvalid = 1'b1;
        nxt_cur.cause = ABP_CAUSE_PFAIL;
      end
      else if (!cur_ff.console && nxt_cur.event_pend)
      begin
        nxt_cur.event_pend = 1'b0;
        nxt_cur.tvalid = 1'b1;
        nxt_cur.cause = ABP_CAUSE_EVENT;
      end
    end
    if (!halt)
      nxt_cur.console = 1'b0;
    case (cur_ff.st)
      ABP_IDLE:
      begin
        if (dmr)
          nxt_cur.st = ABP_GRANT;
        else if (irq4 && !priority_mask_bit && !cur_ff.console
                 && !cur_ff.tvalid)
        begin
          nxt_cur.st = ABP_ACK;
          nxt_cur.din = 1'b1;
          nxt_cur.ack_out = 1'b1;
        end
        else if (cpu_req)
        begin
          nxt_cur.st = ABP_ADDR;
          nxt_cur.dal = cpu_addr;
          nxt_cur.dal_drv = 1'b1;
          nxt_cur.bs7 = is_io_page(cpu_addr);
          nxt_cur.wtbt = cpu_write;
          nxt_cur.dly = '0;
        end
      end
      ABP_ADDR:
      begin
        if (cur_ff.dly == DSK)
        begin
          nxt_cur.sync = 1'b1;
          nxt_cur.dly = '0;
          nxt_cur.st = ABP_SYNC;
        end
        else
          nxt_cur.dly = cur_ff.dly + DCW'(1);
      end
      ABP_SYNC:
      begin
        nxt_cur.bs7 = 1'b0;
        nxt_cur.dly = '0;
        if (cur_ff.wtbt)
        begin
          // only the low word carries data, upper lines held low
          nxt_cur.dal = {{(ABP_AW-ABP_DW){1'b0}}, cpu_wdata};
          nxt_cur.wtbt = cpu_byte;
          nxt_cur.st = ABP_DOUT;
        end
        else
        begin
          nxt_cur.dal_drv = 1'b0;
          nxt_cur.wtbt = 1'b0;
          nxt_cur.din = 1'b1;
          nxt_cur.st = ABP_DIN;
        end
      end
      ABP_DOUT:
      begin
        // data settles for the deskew time before the strobe
        if (!cur_ff.dout && cur_ff.dly == DSK)
          nxt_cur.dout = 1'b1;
        else if (!cur_ff.dout)
          nxt_cur.dly = cur_ff.dly + DCW'(1);
        else if (reply)
        begin
          nxt_cur.dout = 1'b0;
          nxt_cur.wtbt = 1'b0;
          nxt_cur.st = ABP_WAIT_NEG;
        end
      end
      ABP_DIN:
      begin
        if (reply && cur_ff.dly == DSK)
        begin
          nxt_cur.rdata = addr_data_lines_in[ABP_DW-1:0];
          nxt_cur.din = 1'b0;
          nxt_cur.st = ABP_WAIT_NEG;
        end
        else if (reply)
          nxt_cur.dly = cur_ff.dly + DCW'(1);
      end
      ABP_WAIT_NEG:
      begin
        if (!reply)
        begin
          nxt_cur.sync = 1'b0;
          nxt_cur.dal_drv = 1'b0;
          nxt_cur.ready = 1'b1;
          nxt_cur.st = ABP_END;
        end
      end
      ABP_END:
        nxt_cur.st = ABP_IDLE;
      ABP_ACK:
      begin
        if (reply)
        begin
          nxt_cur.rdata = addr_data_lines_in[ABP_DW-1:0];
          nxt_cur.din = 1'b0;
          nxt_cur.ack_out = 1'b0;
          nxt_cur.st = ABP_ACK_END;
        end
      end
      ABP_ACK_END:
      begin
        if (!reply)
        begin
          nxt_cur.tvalid = 1'b1;
          nxt_cur.cause = ABP_CAUSE_IRQ4;
          nxt_cur.st = ABP_IDLE;
        end
      end
      ABP_GRANT:
      begin
        nxt_cur.grant = 1'b1;
        if (sack)
        begin
          nxt_cur.grant = 1'b0;
          nxt_cur.st = ABP_DMA;
        end
        else if (!dmr)
        begin
          nxt_cur.grant = 1'b0;
          nxt_cur.st = ABP_IDLE;
        end
      end
      ABP_DMA:
      begin
        if (!sack)
          nxt_cur.st = ABP_IDLE;
      end
      default:
        nxt_cur.st = ABP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cur_ff <= '0;
      cur_ff.st <= ABP_IDLE;
    end
    else if (clk_en)
      cur_ff <= nxt_cur;
  end

  assign cpu_ready = cur_ff.ready;
  assign cpu_rdata = cur_ff.rdata;
  assign trap_cause = cur_ff.cause;
  assign trap_valid = cur_ff.tvalid;
  assign console_mode = cur_ff.console;
  assign refresh_seen = cur_ff.refr;
  assign trap_vector = (cur_ff.cause == ABP_CAUSE_EVENT) ? ABP_EVENT_VEC :
                       (cur_ff.cause == ABP_CAUSE_PFAIL) ? ABP_PFAIL_VEC :
                       (cur_ff.cause == ABP_CAUSE_IRQ4) ? cur_ff.rdata :
                       ABP_HALT_VEC;
  assign addr_data_lines_out = cur_ff.dal;
  assign addr_data_lines_oe_n = !cur_ff.dal_drv;
  assign sync_strobe_n = !cur_ff.sync;
  assign data_in_strobe_n = !cur_ff.din;
  assign data_out_strobe_n = !cur_ff.dout;
  assign write_byte_select_n = !cur_ff.wtbt;
  assign io_page_select_n = !cur_ff.bs7;
  assign irq_ack_chain_out_n = !cur_ff.ack_out;
  assign dma_grant_out_n = !cur_ff.grant;
  // initialise is driven while reset holds or dc power is missing
  assign bus_initialise_n = !(rst || !dcok);

  grant_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    cur_ff.grant |-> !cur_ff.sync)
    else $error("grant while sync driven");

  sequence halt_held_s;
    halt [*8];
  endsequence
  halt_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && $rose(cur_ff.console) |-> halt_long)
    else $error("console entered without long halt");

  console_exit_a: assert property (@(posedge ref_clk) disable iff (rst)
    halt_held_s ##1 (clk_en && !halt) |=> !cur_ff.console)
    else $error("console kept after halt released");

  pfail_trap_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && trap_valid && trap_cause == ABP_CAUSE_PFAIL
      |-> trap_vector == ABP_PFAIL_VEC)
    else $error("powerfail vector wrong");

  event_vec_a: assert property (@(posedge ref_clk) disable iff (rst)
    trap_cause == ABP_CAUSE_EVENT |-> trap_vector == 16'h0040)
    else $error("event vector not 100 octal");

  dout_data_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cur_ff.dout) |-> cur_ff.dal_drv && cur_ff.sync)
    else $error("data-out without driven data");

  ack_nosync_a: assert property (@(posedge ref_clk) disable iff (rst)
    cur_ff.ack_out |-> cur_ff.din && !cur_ff.sync)
    else $error("acknowledge with sync asserted");

  sync_after_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cur_ff.sync) |-> $past(cur_ff.dal_drv, 2))
    else $error("sync before address settled");

  strobe_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && $fell(cur_ff.din) && !cur_ff.ack_out && cur_ff.sync
      |-> $past(reply))
    else $error("data-in dropped without reply");

  din_wtbt_a: assert property (@(posedge ref_clk) disable iff (rst)
    cur_ff.din && cur_ff.sync |-> !cur_ff.wtbt)
    else $error("write/byte during input cycle");

  mask_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && $rose(cur_ff.ack_out) |-> !$past(priority_mask_bit))
    else $error("acknowledge while masked");
endmodule

// >>> design/abp_pkg.sv
// constants and types shared by the backplane processor bus interface
package abp_pkg;
  localparam int ABP_CLK_MHZ = 250;
  localparam int ABP_HALT_MIN_US = 25;
  localparam int ABP_HALT_CYC = ABP_HALT_MIN_US * ABP_CLK_MHZ;
  localparam int ABP_DESKEW_CYC = 2;
  localparam int ABP_AW = 22;
  localparam int ABP_DW = 16;
  localparam int ABP_IOPAGE_AW = 13;
  localparam logic [15:0] ABP_EVENT_VEC = 16'h0040;
  localparam logic [15:0] ABP_HALT_VEC = 16'h0000;
  localparam logic [15:0] ABP_PFAIL_VEC = 16'h0018;
  localparam logic [2:0] ABP_CAUSE_NONE = 3'h0;
  localparam logic [2:0] ABP_CAUSE_HALT = 3'h1;
  localparam logic [2:0] ABP_CAUSE_PFAIL = 3'h2;
  localparam logic [2:0] ABP_CAUSE_EVENT = 3'h3;
  localparam logic [2:0] ABP_CAUSE_IRQ4 = 3'h4;

  typedef enum logic [3:0] {
    ABP_IDLE, ABP_ADDR, ABP_SYNC, ABP_DIN, ABP_DOUT, ABP_WAIT_NEG,
    ABP_END, ABP_ACK, ABP_ACK_END, ABP_GRANT, ABP_DMA
  } abp_state_t;
endpackage

// >>> design/abp_sync.sv
// two-flop synchroniser bank for backplane inputs
`timescale 1ns/10ps
module abp_sync
  import abp_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else if (clk_en)
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// >>> design/abp_halt_timer.sv
// counts how long halt has been held; flags once the minimum is reached
`timescale 1ns/10ps
module abp_halt_timer
  import abp_pkg::*;
#(
  parameter int HALT_CYC = ABP_HALT_CYC
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic halt_level,
  output logic halt_long
);
  localparam int CW = $clog2(HALT_CYC + 1);
  localparam logic [CW-1:0] LIMIT = CW'(HALT_CYC);
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cnt_ff <= '0;
    else if (clk_en)
    begin
      // release restarts the count, so a glitch never accumulates
      if (!halt_level)
        cnt_ff <= '0;
      else if (cnt_ff != LIMIT)
        cnt_ff <= cnt_ff + CW'(1);
    end
  end

  assign halt_long = (cnt_ff == LIMIT);
endmodule

// >>> test/abp_slave_model.sv
// memory slave and interrupt source model for the far side of the bus
`timescale 1ns/10ps
module abp_slave_model
  import abp_pkg::*;
#(
  parameter logic [15:0] VEC = 16'h00f0
)(
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic bus_initialise_n,
  input wire logic sync_strobe_n,
  input wire logic data_in_strobe_n,
  input wire logic data_out_strobe_n,
  input wire logic write_byte_select_n,
  input wire logic irq_ack_chain_out_n,
  input wire logic [21:0] addr_data_lines_out,
  output logic slave_reply_n,
  output logic [21:0] dal_drive
);
  logic [15:0] mem [0:15];
  logic [4:0] adr;
  int cnt;
  // address is latched at the leading edge of sync
  always @(negedge sync_strobe_n)
    adr = addr_data_lines_out[4:0];
  always_ff @(posedge ref_clk)
  begin
    if (!bus_initialise_n || (data_in_strobe_n && data_out_strobe_n))
    begin
      slave_reply_n <= 1'b1;
      cnt <= 0;
      // released lines keep toggling so stale data never looks valid
      dal_drive <= ~dal_drive;
    end
    else if (cnt < (slow ? 6 : 1))
      cnt <= cnt + 1;
    else if (slave_reply_n)
    begin
      slave_reply_n <= 1'b0;
      if (!data_out_strobe_n && write_byte_select_n)
        mem[adr[4:1]] <= addr_data_lines_out[15:0];
      else if (!data_out_strobe_n && adr[0])
        mem[adr[4:1]][15:8] <= addr_data_lines_out[15:8];
      else if (!data_out_strobe_n)
        mem[adr[4:1]][7:0] <= addr_data_lines_out[7:0];
      else if (sync_strobe_n && !irq_ack_chain_out_n)
        dal_drive <= {6'h00, VEC};
      else
        dal_drive <= {6'h00, mem[adr[4:1]]};
    end
  end
endmodule

// >>> test/abp_arbiter_test.sv
// self-checking bench for the backplane processor bus interface
`timescale 1ns/10ps
module abp_arbiter_test;
  import abp_pkg::*;
  logic ref_clk = 0, rst = 1, clk_en = 1, cpu_req = 0, cpu_write = 0;
  logic cpu_byte = 0, priority_mask_bit = 1, trap_taken = 0, slow = 0;
  logic [21:0] cpu_addr = 22'h00_0000;
  logic [15:0] cpu_wdata = 16'h0000;
  logic dma_request_n = 1, grant_acknowledge_n = 1, processor_halt_n = 1;
  logic memory_refresh_n = 1, external_event_irq_n = 1;
  logic irq_level_four_n = 1, power_ok = 1, dc_power_ok = 1;
  logic cpu_ready, trap_valid, console_mode, addr_data_lines_oe_n;
  logic sync_strobe_n, data_in_strobe_n, data_out_strobe_n;
  logic write_byte_select_n, io_page_select_n, irq_ack_chain_out_n;
  logic dma_grant_out_n, bus_initialise_n, slave_reply_n, refresh_seen;
  logic [15:0] cpu_rdata, trap_vector;
  logic [2:0] trap_cause;
  logic [21:0] addr_data_lines_out, dal_drive, a_cap, d_cap;
  logic wt_cap, bs_cap, wt_d;
  wire [21:0] addr_data_lines_in;
  int err_count = 0, total_checks = 0;
  assign addr_data_lines_in = addr_data_lines_oe_n ? dal_drive
                                                   : addr_data_lines_out;
  abp_arbiter #(.HALT_CYC(20)) abp_arbiter_inst (.ref_clk, .rst, .clk_en,
    .cpu_req, .cpu_write, .cpu_byte, .cpu_addr, .cpu_wdata, .cpu_ready,
    .cpu_rdata, .priority_mask_bit, .trap_cause, .trap_vector, .trap_valid,
    .trap_taken, .console_mode, .addr_data_lines_in, .addr_data_lines_out,
    .addr_data_lines_oe_n, .sync_strobe_n, .data_in_strobe_n,
    .data_out_strobe_n, .write_byte_select_n, .io_page_select_n,
    .irq_ack_chain_out_n, .dma_grant_out_n, .bus_initialise_n,
    .slave_reply_n, .dma_request_n, .grant_acknowledge_n, .processor_halt_n,
    .memory_refresh_n, .external_event_irq_n, .irq_level_four_n, .power_ok,
    .dc_power_ok, .refresh_seen);
  abp_slave_model abp_slave_model_inst (.ref_clk, .slow, .bus_initialise_n,
    .sync_strobe_n, .data_in_strobe_n, .data_out_strobe_n,
    .write_byte_select_n, .irq_ack_chain_out_n, .addr_data_lines_out,
    .slave_reply_n, .dal_drive);
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(negedge sync_strobe_n)
    {a_cap, wt_cap, bs_cap} = {addr_data_lines_out, write_byte_select_n,
                               io_page_select_n};
  always @(negedge data_out_strobe_n)
    {d_cap, wt_d} = {addr_data_lines_out, write_byte_select_n};
  task automatic report_and_stop();
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return cpu_ready;
      1: return bus_initialise_n;
      2: return dma_grant_out_n;
      3: return trap_valid;
      4: return irq_ack_chain_out_n;
      default: return refresh_seen;
    endcase
  endfunction
  // waits at most 300 cycles; a hang ends the run as a mismatch
  task automatic wait_for(input int s, input logic v);
    int i;
    for (i = 0; i < 300 && sig(s) !== v; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (sig(s) !== v)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic cyc(input logic w, input logic b, input logic [21:0] a,
                     input logic [15:0] d);
    @(negedge ref_clk);
    {cpu_req, cpu_write, cpu_byte, cpu_addr, cpu_wdata} = {1'b1, w, b, a, d};
    wait_for(0, 1'b1);
    @(negedge ref_clk);
    cpu_req = 0;
  endtask
  task automatic s_reset();
    repeat (20) @(negedge ref_clk);
    chk(bus_initialise_n, 0);
    rst = 0;
    wait_for(1, 1'b1);
    chk({sync_strobe_n, data_in_strobe_n, data_out_strobe_n}, 3'h7);
  endtask
  task automatic s_rw();
    cyc(1, 0, 22'h00_0010, 16'ha5c3);
    chk({a_cap, wt_cap, bs_cap}, {22'h00_0010, 2'h1});
    chk({d_cap, wt_d}, {6'h00, 16'ha5c3, 1'b1});
    chk(addr_data_lines_oe_n, 1);
    cyc(1, 1, 22'h00_0011, 16'h7e7e);
    chk(wt_d, 0);
    slow = 1;
    cyc(0, 0, 22'h00_0010, 16'h0000);
    chk({cpu_rdata, wt_cap, bs_cap}, {16'h7ec3, 2'h3});
    cyc(0, 0, 22'h3f_e010, 16'h0000);
    chk({cpu_rdata, a_cap[12:0], bs_cap}, {16'h7ec3, 13'h0010, 1'b0});
    slow = 0;
  endtask
  task automatic s_dma();
    @(negedge ref_clk);
    dma_request_n = 0;
    wait_for(2, 1'b0);
    @(negedge ref_clk);
    {dma_request_n, grant_acknowledge_n, cpu_req, cpu_write} = 4'ha;
    wait_for(2, 1'b1);
    repeat (20) @(negedge ref_clk);
    chk({sync_strobe_n, cpu_ready}, 2'h2);
    grant_acknowledge_n = 1;
    wait_for(0, 1'b1);
    @(negedge ref_clk);
    cpu_req = 0;
  endtask
  task automatic take(input logic [2:0] c, input logic [15:0] v);
    wait_for(3, 1'b1);
    chk({trap_cause, trap_vector}, {c, v});
    @(negedge ref_clk);
    trap_taken = 1;
    @(negedge ref_clk);
    trap_taken = 0;
  endtask
  task automatic s_irq();
    @(negedge ref_clk);
    irq_level_four_n = 0;
    repeat (20) @(negedge ref_clk);
    chk(irq_ack_chain_out_n, 1);
    priority_mask_bit = 0;
    wait_for(4, 1'b0);
    @(negedge ref_clk);
    irq_level_four_n = 1;
    take(ABP_CAUSE_IRQ4, 16'h00f0);
  endtask
  task automatic s_traps();
    processor_halt_n = 0;
    repeat (10) @(negedge ref_clk);
    processor_halt_n = 1;
    repeat (10) @(negedge ref_clk);
    chk({trap_valid, console_mode}, 2'h0);
    processor_halt_n = 0;
    take(ABP_CAUSE_HALT, ABP_HALT_VEC);
    chk(console_mode, 1);
    processor_halt_n = 1;
    repeat (6) @(negedge ref_clk);
    chk(console_mode, 0);
    power_ok = 0;
    take(ABP_CAUSE_PFAIL, ABP_PFAIL_VEC);
    power_ok = 1;
    external_event_irq_n = 0;
    repeat (4) @(negedge ref_clk);
    external_event_irq_n = 1;
    take(ABP_CAUSE_EVENT, 16'h0040);
    memory_refresh_n = 0;
    wait_for(5, 1'b1);
    memory_refresh_n = 1;
  endtask
  initial
  begin
    s_reset();
    s_rw();
    s_dma();
    s_irq();
    s_traps();
    repeat (10) @(negedge ref_clk);
    chk(trap_valid, 0);
    report_and_stop();
  end
endmodule
